// [design/ppo_pkg.sv]
// ==========================================================
// Shared constants and types
package ppo_pkg;
  // ==========================================================
  // Clock and base frequency
  localparam int unsigned PPO_CLK_HZ = 25_000_000;
  localparam int unsigned PPO_FREQ_MAX_HZ = 2000; // Fastest base frequency, 2.00 kHz
  localparam int unsigned PPO_PERIOD_MIN_CYC = PPO_CLK_HZ / PPO_FREQ_MAX_HZ;
  localparam int unsigned PPO_PER_DIV = 15; // Period = min period * mult / 15
  localparam int PPO_PER_W = 18;
  localparam logic [2:0] PPO_FREQ_SEL_RST = 3'h4; // 1.00 kHz after reset

  // Period multipliers for 0.125, 0.25, 0.5, 0.75, 1.0, 1.25, 1.5, 2.0 kHz
  function automatic logic [7:0] ppo_per_mult(input logic [2:0] sel);
    logic [7:0] m;
    m = 8'h0f;
    case (sel)
      3'h0: m = 8'hf0;
      3'h1: m = 8'h78;
      3'h2: m = 8'h3c;
      3'h3: m = 8'h28;
      3'h4: m = 8'h1e;
      3'h5: m = 8'h18;
      3'h6: m = 8'h14;
      default: m = 8'h0f;
    endcase
    return m;
  endfunction : ppo_per_mult

  // ==========================================================
  // Duty in units of 1/4000 of the period (0.025 %)
  localparam int unsigned PPO_Q_FULL = 4000;
  localparam logic [11:0] PPO_Q_NORM_LO = 12'h0c8; // 5 %
  localparam logic [11:0] PPO_Q_NORM_HI = 12'hed8; // 95 %
  localparam logic [11:0] PPO_Q_STEP = 12'h024; // 0.9 % per clamp step
  localparam logic [11:0] PPO_Q_DIAG_LO = 12'h064; // 2.5 %
  localparam logic [11:0] PPO_Q_DIAG_HI = 12'hf3c; // 97.5 %
  localparam logic [11:0] PPO_Q_SCALE = 12'he14; // 3604/1024 ~ 3600/1023
  localparam int PPO_Q_SHIFT = 10;

  // ==========================================================
  // Clamp settings in percent
  localparam logic [6:0] PPO_CL_LO_MIN = 7'h05;
  localparam logic [6:0] PPO_CL_LO_MAX = 7'h44;
  localparam logic [6:0] PPO_CL_HI_MIN = 7'h20;
  localparam logic [6:0] PPO_CL_HI_MAX = 7'h5f;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] PPO_REG_CTRL = 8'h00;
  localparam logic [7:0] PPO_REG_OFFSET = 8'h04;
  localparam logic [7:0] PPO_REG_CLAMP = 8'h08;
  localparam logic [7:0] PPO_REG_STATUS = 8'h0c;
  localparam logic [7:0] PPO_REG_CLEAR = 8'h10;
  localparam logic [7:0] PPO_REG_ENABLE = 8'h14;
  localparam logic [7:0] PPO_REG_POS = 8'h18;
  localparam int PPO_CLAMP_HI_LSB = 8;
  localparam int PPO_POS_Q_LSB = 12;

  // Interrupt bits
  localparam int PPO_IRQ_W = 3;
  localparam int PPO_IRQ_PERIOD = 0;
  localparam int PPO_IRQ_FAULT = 1;
  localparam int PPO_IRQ_CLAMP = 2;

  // ==========================================================
  // Types
  typedef struct packed {
    logic diag_high_force;
    logic diag_low_force;
    logic [1:0] ramp_shift;
    logic saw_mode;
    logic slope_fall;
    logic [2:0] freq_sel;
  } ppo_ctrl_s;

  localparam ppo_ctrl_s PPO_CTRL_RST = '{1'b0, 1'b0, 2'h0, 1'b0, 1'b0, PPO_FREQ_SEL_RST};

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ppo_bus_s;
endpackage : ppo_pkg

// [design/ppo_period_timer.sv]
`timescale 1ns/1ps
// ==========================================================
// Period counter; new period length takes effect at the wrap
module ppo_period_timer #(
  parameter int unsigned P_BASE_CYC = ppo_pkg::PPO_PERIOD_MIN_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Frequency choice
  input wire logic [2:0] freq_sel_in,
  // Timing outputs
  output logic wrap_out,
  output logic [ppo_pkg::PPO_PER_W-1:0] cnt_out,
  output logic [ppo_pkg::PPO_PER_W-1:0] period_out,
  output logic [ppo_pkg::PPO_PER_W-1:0] next_period_out
);
  import ppo_pkg::*;

  localparam logic [PPO_PER_W-1:0] L_RST_PERIOD =
    PPO_PER_W'((P_BASE_CYC * 32'(ppo_per_mult(PPO_FREQ_SEL_RST))) / PPO_PER_DIV);

  // Period length for the chosen frequency
  always_comb
  begin
    next_period_out = PPO_PER_W'((P_BASE_CYC * 32'(ppo_per_mult(freq_sel_in))) / PPO_PER_DIV);
  end

  // Last cycle of the running period; >= guards against a stale length
  assign wrap_out = (cnt_out >= period_out - PPO_PER_W'(1));

  // Cycle counter
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      cnt_out <= '0;
    else if (wrap_out)
      cnt_out <= '0;
    else
      cnt_out <= cnt_out + PPO_PER_W'(1);
  end

  // Frequency changes only at the boundary, so no period is cut short
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      period_out <= L_RST_PERIOD;
    else if (wrap_out)
      period_out <= next_period_out;
  end
endmodule : ppo_period_timer

// [design/ppo_duty_map.sv]
`timescale 1ns/1ps
// ==========================================================
// Angle to position to duty mapping, purely combinational
module ppo_duty_map (
  // Settings
  input wire ppo_pkg::ppo_ctrl_s ctrl_in,
  input wire logic [9:0] offset_in,
  input wire logic [6:0] clamp_lo_in,
  input wire logic [6:0] clamp_hi_in,
  // Position and faults
  input wire logic [9:0] angle_in,
  input wire logic fault_low_in,
  input wire logic fault_high_in,
  // Results
  output logic [9:0] pos_out,
  output logic [11:0] q_out,
  output logic [11:0] q_lo_out,
  output logic [11:0] q_hi_out,
  output logic clamped_out,
  output logic diag_lo_out,
  output logic diag_hi_out
);
  import ppo_pkg::*;

  logic [9:0] rel;
  logic [9:0] dir;
  logic [21:0] prod;
  logic [11:0] q_norm;

  // Zero offset, slope, then single or repeating ramp
  always_comb
  begin
    rel = angle_in - offset_in; // [R10]
    dir = ctrl_in.slope_fall ? ~rel : rel; // [R09]
    if (ctrl_in.saw_mode)
      pos_out = dir << ctrl_in.ramp_shift; // [R10]
    else
      pos_out = dir; // [R02]
  end

  // Code 0 to 1023 onto 5 % to 95 %
  always_comb
  begin
    prod = 22'(pos_out) * 22'(PPO_Q_SCALE);
    q_norm = PPO_Q_NORM_LO + 12'(prod >> PPO_Q_SHIFT); // [R03]
  end

  // Clamp levels, 0.9 % of period per percent step
  always_comb
  begin
    q_lo_out = PPO_Q_NORM_LO + 12'(PPO_Q_STEP * 12'(clamp_lo_in - PPO_CL_LO_MIN)); // [R04]
    q_hi_out = PPO_Q_NORM_HI - 12'(PPO_Q_STEP * 12'(PPO_CL_HI_MAX - clamp_hi_in)); // [R04]
  end

  // Fault overrides; low diagnostic wins when both are asserted
  always_comb
  begin
    diag_lo_out = fault_low_in | ctrl_in.diag_low_force;
    diag_hi_out = (fault_high_in | ctrl_in.diag_high_force) & ~diag_lo_out;
    clamped_out = 1'b0;
    if (diag_lo_out)
      q_out = PPO_Q_DIAG_LO; // [R05] [R11]
    else if (diag_hi_out)
      q_out = PPO_Q_DIAG_HI; // [R06] [R11]
    else if (q_norm < q_lo_out)
    begin
      // Low clamp checked first; a crossed pair is the setter's fault [R08]
      q_out = q_lo_out; // [R11]
      clamped_out = 1'b1;
    end
    else if (q_norm > q_hi_out)
    begin
      q_out = q_hi_out; // [R11]
      clamped_out = 1'b1;
    end
    else
      q_out = q_norm;
  end
endmodule : ppo_duty_map

// [design/ppo_top.sv]
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
// Notes on behaviour
// R01: Base frequency chosen from eight values 0.125 to 2.00 kHz.
// R02: Position is a 10-bit code, 0 to 1023 across the range.
// R03: Full position range maps linearly onto 5 % to 95 % duty.
// R04: Each clamp percent step moves the clamp duty by 0.9 %.
// R05: Low diagnostic emits 2.5 % duty, never above 4 %.
// R06: High diagnostic emits 97.5 % duty, never below 96 %.
// R07: Low clamp 5 to 68 percent, high clamp 32 to 95 percent.
// R08: Configuring party keeps low clamp strictly below high clamp.
// R09: Slope bit picks rising or falling output against angle.
// R10: Zero offset plus single linear or repeating sawtooth ramp.
// R11: Out-of-clamp positions saturate; faults force a diagnostic level.
// R12: Period and high time counted in clocks; duty updates at boundaries.
module ppo_top #(
  parameter int unsigned P_BASE_CYC = ppo_pkg::PPO_PERIOD_MIN_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Register port
  input wire ppo_pkg::ppo_bus_s bus_in,
  output logic [31:0] rdata_out,
  // Sensor side
  input wire logic [9:0] angle_in,
  input wire logic fault_low_in,
  input wire logic fault_high_in,
  // Open-drain output pin
  output logic pwm_out,
  output logic pwm_oe_n_out,
  // Interrupt
  output logic irq_out
);
  import ppo_pkg::*;

  ppo_ctrl_s ctrl;
  logic [9:0] offset;
  logic [6:0] clamp_lo;
  logic [6:0] clamp_hi;
  logic [PPO_IRQ_W-1:0] status;
  logic [PPO_IRQ_W-1:0] irq_en;
  logic [PPO_IRQ_W-1:0] events;
  logic [PPO_IRQ_W-1:0] clr_mask;
  logic [31:0] next_rdata;
  logic wrap;
  logic [PPO_PER_W-1:0] cnt;
  logic [PPO_PER_W-1:0] period;
  logic [PPO_PER_W-1:0] next_period;
  logic [PPO_PER_W-1:0] hi_cyc;
  logic [PPO_PER_W-1:0] next_hi_cyc;
  logic [9:0] map_pos;
  logic [11:0] map_q;
  logic [11:0] map_q_lo;
  logic [11:0] map_q_hi;
  logic map_clamped;
  logic map_diag_lo;
  logic map_diag_hi;
  logic [9:0] pos_q;
  logic [11:0] duty_q;
  logic diag_q;

  // Keep a setting inside its allowed span
  function automatic logic [6:0] ppo_sat(input logic [6:0] v, input logic [6:0] lo,
                                         input logic [6:0] hi);
    logic [6:0] r;
    r = v;
    if (v < lo)
      r = lo;
    else if (v > hi)
      r = hi;
    return r;
  endfunction : ppo_sat

  // ==========================================================
  // Period timing
  ppo_period_timer #(
    .P_BASE_CYC(P_BASE_CYC)
  ) u_timer (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .freq_sel_in(ctrl.freq_sel), // [R01]
    .wrap_out(wrap),
    .cnt_out(cnt),
    .period_out(period),
    .next_period_out(next_period)
  );

  // ==========================================================
  // Position and duty mapping
  ppo_duty_map u_map (
    .ctrl_in(ctrl),
    .offset_in(offset),
    .clamp_lo_in(clamp_lo),
    .clamp_hi_in(clamp_hi),
    .angle_in(angle_in),
    .fault_low_in(fault_low_in),
    .fault_high_in(fault_high_in),
    .pos_out(map_pos),
    .q_out(map_q),
    .q_lo_out(map_q_lo),
    .q_hi_out(map_q_hi),
    .clamped_out(map_clamped),
    .diag_lo_out(map_diag_lo),
    .diag_hi_out(map_diag_hi)
  );

  // ==========================================================
  // Register writes
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ctrl <= PPO_CTRL_RST;
      offset <= '0;
      irq_en <= '0;
    end
    else if (bus_in.wr)
    begin
      case (bus_in.addr)
        PPO_REG_CTRL: ctrl <= ppo_ctrl_s'(bus_in.wdata[$bits(ppo_ctrl_s)-1:0]);
        PPO_REG_OFFSET: offset <= bus_in.wdata[9:0];
        PPO_REG_ENABLE: irq_en <= bus_in.wdata[PPO_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Clamp settings saturate so no write can leave the legal span
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      clamp_lo <= PPO_CL_LO_MIN;
      clamp_hi <= PPO_CL_HI_MAX;
    end
    else if (bus_in.wr && bus_in.addr == PPO_REG_CLAMP)
    begin
      clamp_lo <= ppo_sat(bus_in.wdata[6:0], PPO_CL_LO_MIN, PPO_CL_LO_MAX); // [R07]
      clamp_hi <= ppo_sat(bus_in.wdata[PPO_CLAMP_HI_LSB +: 7], PPO_CL_HI_MIN,
                          PPO_CL_HI_MAX); // [R07]
    end
  end

  // ==========================================================
  // Duty latch; high time from the period that starts next
  always_comb
  begin
    next_hi_cyc = PPO_PER_W'((32'(next_period) * 32'(map_q)) / PPO_Q_FULL); // [R12]
  end

  // Values change only at the wrap so every period is whole
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      pos_q <= '0;
      duty_q <= PPO_Q_NORM_LO;
      hi_cyc <= '0;
      diag_q <= 1'b0;
    end
    else if (wrap)
    begin
      pos_q <= map_pos;
      duty_q <= map_q; // [R12]
      hi_cyc <= next_hi_cyc; // [R12]
      diag_q <= map_diag_lo | map_diag_hi;
    end
  end

  // ==========================================================
  // Pin: pulled low by the device, high through the external pull-up
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      pwm_out <= 1'b0;
      pwm_oe_n_out <= 1'b0;
    end
    else
    begin
      pwm_out <= (cnt < hi_cyc); // [R12]
      pwm_oe_n_out <= (cnt < hi_cyc);
    end
  end

  // ==========================================================
  // Interrupt status; set wins over a clear in the same cycle
  always_comb
  begin
    events = '0;
    events[PPO_IRQ_PERIOD] = wrap;
    events[PPO_IRQ_FAULT] = wrap & (map_diag_lo | map_diag_hi) & ~diag_q;
    events[PPO_IRQ_CLAMP] = wrap & map_clamped;
    clr_mask = (bus_in.wr && bus_in.addr == PPO_REG_CLEAR) ?
               bus_in.wdata[PPO_IRQ_W-1:0] : '0;
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      status <= '0;
    else
      status <= (status & ~clr_mask) | events;
  end

  // Level output, one cycle behind the status bits
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      irq_out <= 1'b0;
    else
      irq_out <= |(status & irq_en);
  end

  // ==========================================================
  // Register reads; data valid only in the cycle after the strobe
  always_comb
  begin
    next_rdata = '0;
    if (bus_in.rd)
    begin
      case (bus_in.addr)
        PPO_REG_CTRL: next_rdata[$bits(ppo_ctrl_s)-1:0] = ctrl;
        PPO_REG_OFFSET: next_rdata[9:0] = offset;
        PPO_REG_CLAMP:
        begin
          next_rdata[6:0] = clamp_lo;
          next_rdata[PPO_CLAMP_HI_LSB +: 7] = clamp_hi;
        end
        PPO_REG_STATUS: next_rdata[PPO_IRQ_W-1:0] = status;
        PPO_REG_ENABLE: next_rdata[PPO_IRQ_W-1:0] = irq_en;
        PPO_REG_POS:
        begin
          next_rdata[9:0] = pos_q;
          next_rdata[PPO_POS_Q_LSB +: 12] = duty_q;
        end
        default: next_rdata = '0; // Unmapped and write-only read as zero
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      rdata_out <= '0;
    else
      rdata_out <= next_rdata;
  end

  // ==========================================================
  // Assertions
  default clocking ppo_cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);

  a_freq_period: assert property (wrap |-> cnt == period - PPO_PER_W'(1) ##1
                                  (cnt == '0 && period == $past(next_period))) // [R01]
    else $error("period length or reload wrong");

  a_duty_boundary: assert property ($changed(duty_q) |-> $past(wrap)) // [R12]
    else $error("duty changed inside a period");

  a_pin_timing: assert property (##1 pwm_out == ($past(cnt) < $past(hi_cyc))) // [R12]
    else $error("pin level does not follow high time");

  a_diag_low: assert property (wrap && map_diag_lo |=> duty_q == PPO_Q_DIAG_LO
                               && duty_q <= 12'ha0) // [R05]
    else $error("low diagnostic duty wrong");

  a_diag_high: assert property (wrap && map_diag_hi |=> duty_q == PPO_Q_DIAG_HI
                                && duty_q >= 12'hf00) // [R06]
    else $error("high diagnostic duty wrong");

  a_normal_span: assert property (wrap && !map_diag_lo && !map_diag_hi |=>
                                  duty_q >= PPO_Q_NORM_LO && duty_q <= PPO_Q_NORM_HI) // [R03]
    else $error("normal duty outside 5 to 95 percent");

  a_clamp_sat: assert property (wrap && !map_diag_lo && !map_diag_hi && map_q_lo < map_q_hi
                                |=> duty_q >= $past(map_q_lo) && duty_q <= $past(map_q_hi)) // [R11]
    else $error("duty escapes the clamp levels");

  a_clamp_step: assert property (map_q_lo == PPO_Q_NORM_LO + 12'(12'h024 * 12'(clamp_lo - 7'h05))
                                 && map_q_hi <= PPO_Q_NORM_HI) // [R04]
    else $error("clamp duty step not 0.9 percent");

  a_clamp_limits: assert property (clamp_lo >= PPO_CL_LO_MIN && clamp_lo <= PPO_CL_LO_MAX
                                   && clamp_hi >= PPO_CL_HI_MIN && clamp_hi <= PPO_CL_HI_MAX) // [R07]
    else $error("clamp setting out of range");

  a_linear_map: assert property (wrap && !ctrl.saw_mode && !ctrl.slope_fall |=>
                                 pos_q == $past(10'(angle_in - offset))) // [R02] [R10]
    else $error("rising linear position wrong");

  a_slope_fall: assert property (wrap && !ctrl.saw_mode && ctrl.slope_fall |=>
                                 pos_q == ~$past(10'(angle_in - offset))) // [R09]
    else $error("falling slope position wrong");

  // Other enabled bits may also hold the line high, so only a missing level is an error
  a_sticky_set: assert property (wrap |=> status[PPO_IRQ_PERIOD] ##1 // [R12]
                                 (irq_out || !$past(irq_en[PPO_IRQ_PERIOD])))
    else $error("period event lost or interrupt level wrong");

  c_diag_low: cover property (wrap && map_diag_lo ##1 duty_q == PPO_Q_DIAG_LO);
  c_clamped: cover property (wrap && map_clamped);
  c_sawtooth: cover property (wrap && ctrl.saw_mode && ctrl.ramp_shift != 2'h0);
  c_irq: cover property ($rose(irq_out));
endmodule : ppo_top

// [bench/ppo_host_model.sv]
`timescale 1ns/1ps
// ==========================================================
// Host duty decoder behind the pull-up
module ppo_host_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Pin enable from the device
  input wire logic oe_n_in,
  // One measured period
  output logic valid_out,
  output logic [ppo_pkg::PPO_PER_W-1:0] period_out,
  output logic [ppo_pkg::PPO_PER_W-1:0] high_out
);
  import ppo_pkg::*;

  logic pin;
  logic pin_d;
  logic seen;
  logic [ppo_pkg::PPO_PER_W-1:0] cnt;
  logic [ppo_pkg::PPO_PER_W-1:0] hcnt;

  // Released pin reads high through the pull-up, driven pin reads low
  assign pin = oe_n_in ? 1'b1 : 1'b0;

  // Rising edge to rising edge; the partial first period is dropped
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      pin_d <= 1'b1;
      seen <= 1'b0;
      valid_out <= 1'b0;
      period_out <= 18'h0;
      high_out <= 18'h0;
      cnt <= 18'h0;
      hcnt <= 18'h0;
    end
    else
    begin
      pin_d <= pin;
      valid_out <= pin && !pin_d && seen;
      if (pin && !pin_d)
      begin
        seen <= 1'b1;
        period_out <= cnt;
        high_out <= hcnt;
        cnt <= 18'h1;
        hcnt <= 18'h1;
      end
      else
      begin
        cnt <= cnt + 18'h1;
        hcnt <= hcnt + {17'h0, pin};
      end
    end
  end
endmodule : ppo_host_model

// [bench/test_position_pwm_output.sv]
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench
module test_position_pwm_output;
  import ppo_pkg::*;
  localparam int unsigned BASE = 150; // Short periods keep the run brief
  logic clk_in;
  logic arst_n_in;
  ppo_bus_s bus;
  logic [31:0] rdata;
  logic [9:0] angle;
  logic f_lo;
  logic f_hi;
  logic pwm;
  logic oe_n;
  logic irq;
  logic m_v;
  logic [17:0] m_per;
  logic [17:0] m_hi;
  int fail_count;
  int total_checks;
  int meas_count;
  int cycles;
  int mult[8] = '{240, 120, 60, 40, 30, 24, 20, 15};
  logic [63:0] rd_q[$];
  logic [35:0] pwm_q[$];
  logic [63:0] rn;
  logic [35:0] pn;
  logic rd_prev;
  ppo_ctrl_s ctrl;
  logic [9:0] off;
  logic [6:0] lo;
  logic [6:0] hi;

  ppo_top #(.P_BASE_CYC(BASE)) i_dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .bus_in(bus),
    .rdata_out(rdata), .angle_in(angle), .fault_low_in(f_lo), .fault_high_in(f_hi),
    .pwm_out(pwm), .pwm_oe_n_out(oe_n), .irq_out(irq));
  ppo_host_model i_host (.clk_in(clk_in), .arst_n_in(arst_n_in), .oe_n_in(oe_n),
    .valid_out(m_v), .period_out(m_per), .high_out(m_hi));

  // 25 MHz clock
  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  task automatic close_out();
    if (fail_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Bus cycles leave one idle edge so no signal is assigned twice at once
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_in);
    bus <= '0;
    @(posedge clk_in);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    rd_q.push_back({m, e});
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk_in);
    bus <= '0;
    @(posedge clk_in);
  endtask : rd

  // Expected duty in 1/4000 units, position by reference
  function automatic int exp_q(output int pos);
    int q;
    int ql;
    int qh;
    pos = (int'(angle) - int'(off)) & 1023;
    if (ctrl.slope_fall)
      pos = 1023 - pos;
    if (ctrl.saw_mode)
      pos = (pos << ctrl.ramp_shift) & 1023;
    if (f_lo || ctrl.diag_low_force)
      return 100;
    if (f_hi || ctrl.diag_high_force)
      return 3900;
    q = 200 + ((pos * 3604) >> 10);
    ql = 200 + 36 * (int'(lo) - 5);
    qh = 3800 - 36 * (95 - int'(hi));
    if (q < ql)
      q = ql;
    else if (q > qh)
      q = qh;
    return q;
  endfunction : exp_q

  // Program settings, let two periods pass, then expect the next one
  task automatic apply(input logic [9:0] a, input logic fl, input logic fh);
    int per;
    int q;
    int pos;
    int n;
    wr(PPO_REG_CTRL, {23'h0, ctrl});
    wr(PPO_REG_OFFSET, {22'h0, off});
    wr(PPO_REG_CLAMP, {16'h0, 1'b0, hi, 1'b0, lo});
    angle <= a;
    f_lo <= fl;
    f_hi <= fh;
    @(posedge clk_in);
    per = BASE * mult[ctrl.freq_sel] / 15;
    q = exp_q(pos);
    n = meas_count;
    wait (meas_count >= n + 2);
    pwm_q.push_back({per[17:0], 18'(per * q / 4000)});
    wait (pwm_q.size() == 0);
    @(posedge clk_in);
    if (q >= 200 && q <= 3800)
      rd(PPO_REG_POS, {8'h0, q[11:0], 2'h0, pos[9:0]}, 32'h00fff3ff);
  endtask : apply

  // ==========================================================
  // Watchers: read data one cycle after the strobe, one result per period
  always @(negedge clk_in)
  begin
    if (rd_prev && rd_q.size() > 0)
    begin
      rn = rd_q.pop_front();
      chk("rdata", rn[31:0], rdata & rn[63:32]);
    end
    rd_prev = bus.rd;
    if (m_v && pwm_q.size() > 0)
    begin
      pn = pwm_q.pop_front();
      chk("period", {14'h0, pn[35:18]}, {14'h0, m_per});
      chk("high_time", {14'h0, pn[17:0]}, {14'h0, m_hi});
      chk("pwm_level", 32'h1, {31'h0, pwm});
    end
    if (m_v)
      meas_count++;
  end

  // Hang guard
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles > 90000)
    begin
      fail_count++;
      close_out();
    end
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    bus = '0;
    angle = 10'h0;
    f_lo = 1'b0;
    f_hi = 1'b0;
    arst_n_in = 1'b0;
    rd_prev = 1'b0;
    ctrl = PPO_CTRL_RST;
    off = 10'h0;
    lo = 7'h05;
    hi = 7'h5f;
    void'($urandom(34));
    repeat (6) @(posedge clk_in);
    arst_n_in <= 1'b1;
    @(posedge clk_in);
    rd(PPO_REG_CTRL, 32'h00000004, 32'hffffffff);
    rd(PPO_REG_CLAMP, 32'h00005f05, 32'hffffffff);
    rd(8'h40, 32'h0, 32'hffffffff);
    for (int i = 0; i < 8; i++)
    begin
      ctrl.freq_sel = 3'(i);
      apply(10'($urandom % 1024), 1'b0, 1'b0);
    end
    apply(10'h000, 1'b0, 1'b0);
    apply(10'h3ff, 1'b0, 1'b0);
    ctrl.slope_fall = 1'b1;
    apply(10'($urandom % 1024), 1'b0, 1'b0);
    ctrl.slope_fall = 1'b0;
    off = 10'($urandom % 1024);
    apply(10'($urandom % 1024), 1'b0, 1'b0);
    ctrl.saw_mode = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      ctrl.ramp_shift = 2'(i);
      apply(10'($urandom % 1024), 1'b0, 1'b0);
    end
    ctrl.saw_mode = 1'b0;
    off = 10'h0;
    lo = 7'h14;
    hi = 7'h28;
    apply(10'h000, 1'b0, 1'b0);
    apply(10'h3ff, 1'b0, 1'b0);
    lo = 7'h44;
    hi = 7'h45; // Low clamp must stay strictly below the high clamp
    apply(10'h000, 1'b0, 1'b0);
    lo = 7'h05;
    hi = 7'h20;
    apply(10'h3ff, 1'b0, 1'b0);
    wr(PPO_REG_CLAMP, 32'h00006302);
    rd(PPO_REG_CLAMP, 32'h00005f05, 32'hffffffff);
    hi = 7'h5f;
    apply(10'h200, 1'b1, 1'b0);
    apply(10'h200, 1'b0, 1'b1);
    apply(10'h200, 1'b1, 1'b1);
    ctrl.diag_high_force = 1'b1;
    apply(10'h100, 1'b0, 1'b0);
    ctrl.diag_high_force = 1'b0;
    ctrl.diag_low_force = 1'b1;
    apply(10'h100, 1'b0, 1'b0);
    ctrl.diag_low_force = 1'b0;
    apply(10'h200, 1'b0, 1'b0);
    // Interrupts: start just after a wrap so the next one is far off
    @(posedge oe_n);
    @(posedge clk_in);
    wr(PPO_REG_CLEAR, 32'h7);
    rd(PPO_REG_STATUS, 32'h0, 32'h7);
    wr(PPO_REG_ENABLE, 32'h1);
    @(posedge oe_n);
    repeat (3) @(posedge clk_in);
    chk("irq", 32'h1, {31'h0, irq});
    rd(PPO_REG_STATUS, 32'h1, 32'h1);
    wr(PPO_REG_ENABLE, 32'h0);
    repeat (2) @(posedge clk_in);
    chk("irq", 32'h0, {31'h0, irq});
    wr(PPO_REG_ENABLE, 32'h2);
    f_lo <= 1'b1;
    repeat (2) @(posedge oe_n);
    repeat (2) @(posedge clk_in);
    chk("irq", 32'h1, {31'h0, irq});
    rd(PPO_REG_STATUS, 32'h2, 32'h2);
    wr(PPO_REG_CLEAR, 32'h2);
    repeat (2) @(posedge clk_in);
    chk("irq", 32'h0, {31'h0, irq});
    f_lo <= 1'b0;
    close_out();
  end
endmodule : test_position_pwm_output
